// [common/rrc_pkg.sv]
// shared constants and types of the registration response codec
package rrc_pkg;
  // ********************************
  // sizes and type codes
  // ********************************
  localparam int CAP_MAX = 8;
  localparam int CLS_MAX = 16;
  localparam logic [3:0] CAP_CNT = 4'h8;
  localparam logic [4:0] CLS_CNT = 5'h10;
  localparam logic [7:0] T_CAP = 8'h05;
  localparam logic [7:0] T_LEG_REQ = 8'h04;
  localparam logic [7:0] T_LEG_RSP = 8'h01;
  localparam logic [7:0] ST_ID = 8'h01;
  localparam logic [7:0] ST_SVC = 8'h02;
  localparam logic [7:0] L_ID = 8'h01;
  localparam logic [7:0] L_SVC = 8'h02;
  localparam logic [7:0] L_LEG = 8'h07;
  localparam logic [7:0] L_CAP_VAL = 8'h02;
  localparam logic [7:0] ID_MIN = 8'h01;
  localparam logic [7:0] ID_MAX = 8'h10;
  localparam logic [7:0] CODE_OK = 8'h00;
  localparam logic [7:0] CODE_AUTH = 8'h01;
  localparam logic [7:0] CODE_COS = 8'h02;

  // ********************************
  // types
  // ********************************
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rrc_byte_s;

  typedef enum logic [2:0] {
    PH_TYPE = 3'h1,
    PH_LEN = 3'h2,
    PH_VAL = 3'h4
  } rrc_ph_e;

  typedef struct packed {
    rrc_ph_e ph;
    logic [7:0] typ;
    logic [7:0] rem;
  } rrc_tlv_s;

  typedef enum logic [4:0] {
    S_RX = 5'h01,
    S_CAPH = 5'h02,
    S_CAP = 5'h04,
    S_LEG = 5'h08,
    S_END = 5'h10
  } rrc_state_e;

  typedef struct packed {
    rrc_state_e st;
    logic [3:0] cap_n;
    logic cs;
    logic [CAP_MAX-1:0][7:0] cap_typ;
    logic [CAP_MAX-1:0][7:0] cap_len;
    logic [CAP_MAX-1:0][1:0][7:0] cap_val;
    logic [7:0] cap_tot;
    logic [4:0] cls_n;
    logic [CLS_MAX-1:0][4:0] cls_id;
    logic [CLS_MAX-1:0] cls_seen;
    logic cls_hasid;
    logic cls_bad;
    logic [3:0] ei;
    logic [8:0] bi;
    rrc_byte_s out;
    logic ov;
    logic [7:0] code;
    logic done;
  } rrc_main_s;
endpackage

// [rtl/rrc_tlv_walk.sv]
// sequential type-length-value walker
`timescale 1ns/1ps
module rrc_tlv_walk (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic restart, // next byte is a type byte
  input wire logic stb, // byte present
  input wire logic [7:0] data, // byte value
  output rrc_pkg::rrc_tlv_s cur // role of the present byte
);
  rrc_pkg::rrc_tlv_s q;
  rrc_pkg::rrc_tlv_s d;

  assign cur = q;

  // ********************************
  // walk
  // ********************************
  always_comb begin
    d = q;
    if (restart) begin
      d.ph = rrc_pkg::PH_TYPE;
      d.rem = 8'h00;
    end else if (stb) begin
      case (q.ph)
        rrc_pkg::PH_TYPE: begin
          d.typ = data;
          d.ph = rrc_pkg::PH_LEN;
        end
        rrc_pkg::PH_LEN: begin
          d.rem = data;
          d.ph = (data == 8'h00) ? rrc_pkg::PH_TYPE : rrc_pkg::PH_VAL;
        end
        rrc_pkg::PH_VAL: begin
          d.rem = q.rem - 8'h01;
          if (q.rem == 8'h01) begin
            d.ph = rrc_pkg::PH_TYPE;
          end
        end
        default: d.ph = rrc_pkg::PH_TYPE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.ph <= rrc_pkg::PH_TYPE;
    end else begin
      q <= d;
    end
  end

  // ********************************
  // checks
  // ********************************
  sequence s_len_byte;
    stb && !restart && q.ph == rrc_pkg::PH_LEN;
  endsequence

  a_type_octet: assert property (@(posedge clk) disable iff (rst)
    (stb && !restart && q.ph == rrc_pkg::PH_TYPE)
    |=> (q.ph == rrc_pkg::PH_LEN && q.typ == $past(data)))
    else $error("type byte not taken as one octet");

  a_len_skip: assert property (@(posedge clk) disable iff (rst)
    (s_len_byte and data != 8'h00)
    |=> (q.ph == rrc_pkg::PH_VAL && q.rem == $past(data)))
    else $error("length byte not loaded");

  a_zero_len: assert property (@(posedge clk) disable iff (rst)
    (s_len_byte and data == 8'h00) |=> q.ph == rrc_pkg::PH_TYPE)
    else $error("empty entry not skipped");
endmodule

// [rtl/rrc_codec.sv]
// headend registration response codec: request parse, response build
`timescale 1ns/1ps
// Operation
// - type and length fields are one octet
// - granted capability with a value of up to two octets echoes the requested value
// - unrecognised capability returned with value zero
// - only capabilities present in request returned
// - requested off stays off
// - one legacy entry, type 1, per request class
// - each legacy entry holds one class
// - bad or duplicate class id gives failure
// - missing class id gives failure, no legacy entries
// - subtype 1.1, length 1, copied class id
// - subtype 1.2, length 2, assigned service identifier
// - legacy codes 0 okay, 1 auth, 2 class
module rrc_codec (
  input wire logic clk, // system clock, 50 MHz
  input wire logic rst, // sync reset, high
  input wire logic req_valid, // request byte offered
  output logic req_ready, // request byte taken
  input wire rrc_pkg::rrc_byte_s req_byte, // request byte, last of message
  input wire logic [31:0] cap_known, // capability types recognised
  input wire logic [31:0] cap_grant, // capability types allowed on
  input wire logic auth_fail, // authentication failed
  input wire logic [7:0] flow_code, // code for flow registrations
  input wire logic [15:0] svc_base, // service identifier base
  output logic rsp_valid, // response byte offered
  input wire logic rsp_ready, // response byte taken
  output rrc_pkg::rrc_byte_s rsp_byte, // response byte, last of message
  output logic [7:0] rsp_code, // response code
  output logic rsp_done, // response finished, pulse
  output logic busy // building a response
);
  rrc_pkg::rrc_main_s q;
  rrc_pkg::rrc_main_s d;
  rrc_pkg::rrc_tlv_s ow;
  rrc_pkg::rrc_tlv_s iw;
  logic take;
  logic adv;
  logic leg;
  logic [2:0] ci;

  // ********************************
  // helpers
  // ********************************
  function automatic logic is_known(input logic [7:0] typ, input logic [31:0] kn);
    is_known = (typ[7:5] == 3'h0) && kn[typ[4:0]];
  endfunction

  function automatic logic [7:0] cap_out(input logic [7:0] typ, input logic [7:0] len,
      input logic [1:0][7:0] val, input logic [8:0] bi, input logic [31:0] kn,
      input logic [31:0] gr);
    logic pass;
    pass = is_known(typ, kn) && gr[typ[4:0]] && len <= rrc_pkg::L_CAP_VAL;
    cap_out = (pass && bi < 9'h004) ? val[bi[0]] : 8'h00;
  endfunction

  function automatic logic [15:0] svc_of(input logic [15:0] base, input logic [4:0] id);
    svc_of = base + {11'h000, id};
  endfunction

  function automatic logic [7:0] leg_out(input logic [3:0] bi, input logic [4:0] id,
      input logic [15:0] svc);
    case (bi)
      4'h0: leg_out = rrc_pkg::T_LEG_RSP;
      4'h1: leg_out = rrc_pkg::L_LEG;
      4'h2: leg_out = rrc_pkg::ST_ID;
      4'h3: leg_out = rrc_pkg::L_ID;
      4'h4: leg_out = {3'h0, id};
      4'h5: leg_out = rrc_pkg::ST_SVC;
      4'h6: leg_out = rrc_pkg::L_SVC;
      4'h7: leg_out = svc[15:8];
      default: leg_out = svc[7:0];
    endcase
  endfunction

  assign take = req_valid && req_ready;
  assign adv = !q.ov || rsp_ready;
  assign leg = q.code == rrc_pkg::CODE_OK && q.cls_n != 5'h00;
  assign ci = q.ei[2:0];
  assign req_ready = q.st == rrc_pkg::S_RX;
  assign rsp_valid = q.ov;
  assign rsp_byte = q.out;
  assign rsp_code = q.code;
  assign rsp_done = q.done;
  assign busy = q.st != rrc_pkg::S_RX;

  // outer walk over the message, inner walk inside one entry
  rrc_tlv_walk u_outer (
    .clk(clk),
    .rst(rst),
    .restart(take && req_byte.last),
    .stb(take),
    .data(req_byte.data),
    .cur(ow)
  );

  rrc_tlv_walk u_inner (
    .clk(clk),
    .rst(rst),
    .restart(take && ow.ph != rrc_pkg::PH_VAL),
    .stb(take && ow.ph == rrc_pkg::PH_VAL),
    .data(req_byte.data),
    .cur(iw)
  );

  // ********************************
  // parse and build
  // ********************************
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (q.ov && rsp_ready) begin
      d.ov = 1'b0;
    end
    case (q.st)
      rrc_pkg::S_RX: begin
        if (take) begin
          if (ow.ph == rrc_pkg::PH_LEN && ow.typ == rrc_pkg::T_LEG_REQ) begin
            d.cls_hasid = 1'b0;
            if (q.cls_n == rrc_pkg::CLS_CNT || req_byte.data == 8'h00) begin
              d.cls_bad = 1'b1;
            end
            if (q.cls_n != rrc_pkg::CLS_CNT) begin
              d.cls_n = q.cls_n + 5'h01;
            end
          end
          if (ow.ph == rrc_pkg::PH_VAL && ow.typ == rrc_pkg::T_LEG_REQ) begin
            if (iw.ph == rrc_pkg::PH_VAL && iw.typ == rrc_pkg::ST_ID && !q.cls_hasid) begin
              d.cls_hasid = 1'b1;
              if (req_byte.data < rrc_pkg::ID_MIN || req_byte.data > rrc_pkg::ID_MAX) begin
                d.cls_bad = 1'b1;
              end else if (q.cls_seen[4'(req_byte.data - rrc_pkg::ID_MIN)]) begin
                d.cls_bad = 1'b1;
              end else begin
                d.cls_seen[4'(req_byte.data - rrc_pkg::ID_MIN)] = 1'b1;
                d.cls_id[4'(q.cls_n - 5'h01)] = req_byte.data[4:0];
              end
            end
            if (ow.rem == 8'h01 && !d.cls_hasid) begin
              d.cls_bad = 1'b1;
            end
          end
          if (ow.ph == rrc_pkg::PH_VAL && ow.typ == rrc_pkg::T_CAP) begin
            if (iw.ph == rrc_pkg::PH_LEN) begin
              d.cs = q.cap_n != rrc_pkg::CAP_CNT;
              if (d.cs) begin
                d.cap_typ[q.cap_n[2:0]] = iw.typ;
                d.cap_len[q.cap_n[2:0]] = req_byte.data;
                d.cap_val[q.cap_n[2:0]] = '0;
                d.cap_n = q.cap_n + 4'h1;
                d.cap_tot = q.cap_tot + req_byte.data + 8'h02;
              end
            end else if (iw.ph == rrc_pkg::PH_VAL && q.cs) begin
              if (q.cap_len[3'(q.cap_n - 4'h1)] - iw.rem < rrc_pkg::L_CAP_VAL) begin
                d.cap_val[3'(q.cap_n - 4'h1)][1'(q.cap_len[3'(q.cap_n - 4'h1)] - iw.rem)] =
                    req_byte.data;
              end
            end
          end
          if (req_byte.last) begin
            if (d.cls_n != 5'h00 || d.cls_bad) begin
              d.code = d.cls_bad ? rrc_pkg::CODE_COS :
                  (auth_fail ? rrc_pkg::CODE_AUTH : rrc_pkg::CODE_OK);
            end else begin
              d.code = flow_code;
            end
            d.bi = 9'h000;
            d.ei = 4'h0;
            if (d.cap_n != 4'h0) begin
              d.st = rrc_pkg::S_CAPH;
            end else if (d.code == rrc_pkg::CODE_OK && d.cls_n != 5'h00) begin
              d.st = rrc_pkg::S_LEG;
            end else begin
              d.st = rrc_pkg::S_END;
            end
          end
        end
      end
      rrc_pkg::S_CAPH: begin
        if (adv) begin
          d.ov = 1'b1;
          d.out.data = (q.bi == 9'h000) ? rrc_pkg::T_CAP : q.cap_tot;
          d.out.last = 1'b0;
          d.bi = q.bi + 9'h001;
          if (q.bi == 9'h001) begin
            d.bi = 9'h000;
            d.st = rrc_pkg::S_CAP;
          end
        end
      end
      rrc_pkg::S_CAP: begin
        if (adv) begin
          d.ov = 1'b1;
          if (q.bi == 9'h000) begin
            d.out.data = q.cap_typ[ci];
          end else if (q.bi == 9'h001) begin
            d.out.data = q.cap_len[ci];
          end else begin
            d.out.data = cap_out(q.cap_typ[ci], q.cap_len[ci], q.cap_val[ci], q.bi,
                cap_known, cap_grant);
          end
          d.out.last = 1'b0;
          d.bi = q.bi + 9'h001;
          if (q.bi == {1'b0, q.cap_len[ci]} + 9'h001) begin
            d.bi = 9'h000;
            d.ei = q.ei + 4'h1;
            if (q.ei == q.cap_n - 4'h1) begin
              d.out.last = !leg;
              d.ei = 4'h0;
              d.st = leg ? rrc_pkg::S_LEG : rrc_pkg::S_END;
            end
          end
        end
      end
      rrc_pkg::S_LEG: begin
        if (adv) begin
          d.ov = 1'b1;
          d.out.data = leg_out(q.bi[3:0], q.cls_id[q.ei],
              svc_of(svc_base, q.cls_id[q.ei]));
          d.out.last = 1'b0;
          d.bi = q.bi + 9'h001;
          if (q.bi == 9'h008) begin
            d.bi = 9'h000;
            d.ei = q.ei + 4'h1;
            if (q.ei == 4'(q.cls_n - 5'h01)) begin
              d.out.last = 1'b1;
              d.st = rrc_pkg::S_END;
            end
          end
        end
      end
      default: begin
        if (!q.ov) begin
          d = '0;
          d.st = rrc_pkg::S_RX;
          d.code = q.code;
          d.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= rrc_pkg::S_RX;
    end else begin
      q <= d;
    end
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cap_val;
    q.st == rrc_pkg::S_CAP && adv && q.bi > 9'h001;
  endsequence

  sequence s_leg_at(logic [3:0] n);
    q.st == rrc_pkg::S_LEG && adv && q.bi == {5'h00, n};
  endsequence

  a_unknown_zero: assert property (
    (s_cap_val and !is_known(q.cap_typ[ci], cap_known)) |=> rsp_byte.data == 8'h00)
    else $error("unrecognised capability not zeroed");

  a_off_stays: assert property (
    (s_cap_val and q.cap_val[ci] == 16'h0000) |=> rsp_byte.data == 8'h00)
    else $error("capability requested off returned on");

  a_echo_value: assert property (
    (s_cap_val and q.bi == 9'h002 and is_known(q.cap_typ[ci], cap_known)
      and cap_grant[q.cap_typ[ci][4:0]] and q.cap_len[ci] <= rrc_pkg::L_CAP_VAL)
    |=> rsp_byte.data == $past(q.cap_val[ci][0]))
    else $error("granted capability value not echoed");

  a_cap_bound: assert property (
    q.st == rrc_pkg::S_CAP |-> q.ei < q.cap_n)
    else $error("capability emitted beyond those requested");

  a_leg_head: assert property (
    s_leg_at(4'h0) |=> rsp_valid && rsp_byte.data == rrc_pkg::T_LEG_RSP)
    else $error("legacy entry type wrong");

  a_one_class: assert property (
    s_leg_at(4'h1) |=> rsp_byte.data == rrc_pkg::L_LEG)
    else $error("legacy entry not one class long");

  a_cos_fail: assert property (
    (take && req_byte.last && d.cls_bad) |=> q.code == rrc_pkg::CODE_COS
      && q.st != rrc_pkg::S_LEG)
    else $error("class failure not reported");

  a_no_leg_fail: assert property (
    q.st == rrc_pkg::S_LEG |-> q.code == rrc_pkg::CODE_OK && !q.cls_bad)
    else $error("legacy entries sent on failure");

  a_id_copy: assert property (
    s_leg_at(4'h4) |=> rsp_byte.data == {3'h0, $past(q.cls_id[q.ei])})
    else $error("class id not copied");

  a_svc_low: assert property (
    s_leg_at(4'h8) |=> rsp_byte.data == $past(svc_of(svc_base, q.cls_id[q.ei]) & 16'h00ff))
    else $error("service identifier wrong");

  a_auth_code: assert property (
    (take && req_byte.last && d.cls_n != 5'h00 && !d.cls_bad && auth_fail)
    |=> q.code == rrc_pkg::CODE_AUTH)
    else $error("authentication failure code wrong");
endmodule

// [tb/rrc_modem_model.sv]
// far-side modem model that takes in the response and acknowledges it
`timescale 1ns/1ps
module rrc_modem_model (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic slow, // stall on every other cycle
  input wire logic rsp_valid, // response byte offered
  output logic rsp_ready, // response byte taken
  input wire rrc_pkg::rrc_byte_s rsp_byte, // response byte, last flag
  input wire logic [7:0] rsp_code, // response code
  input wire logic rsp_done // response finished, pulse
);
  // ********************************
  // byte sink
  // ********************************
  rrc_pkg::rrc_byte_s got[$];
  logic [15:0] ack_svc = 16'h0000; // transaction identifier of last ack
  logic [7:0] ack_code = 8'h00; // confirmation code of last ack
  int ack_n = 0; // acks sent

  // ********************************
  // acknowledgement
  // ********************************
  // transaction identifier is the first assigned service identifier
  task automatic build_ack();
    int i;
    int j;
    i = 0;
    ack_svc = 16'h0000;
    while (i + 1 < got.size()) begin
      if (got[i].data == rrc_pkg::T_LEG_RSP && ack_svc == 16'h0000) begin
        j = i + 2;
        while (j + 1 < i + 2 + int'(got[i + 1].data)) begin
          if (got[j].data == rrc_pkg::ST_SVC) begin
            ack_svc = {got[j + 2].data, got[j + 3].data};
          end
          j = j + 2 + int'(got[j + 1].data);
        end
      end
      i = i + 2 + int'(got[i + 1].data);
    end
    ack_code = rsp_code;
    // all items taken, all channels acquired: no error sets, no channel entries
    ack_n++;
  endtask

  // upstream channel change request: dropped, no ack and no state change
  task automatic chg_req();
  endtask

  // ready changes only just after an edge, as a real sink would
  always @(posedge clk) begin
    if (rst) begin
      rsp_ready <= 1'b0;
    end else begin
      if (rsp_valid && rsp_ready) begin
        got.push_back(rsp_byte);
      end
      if (rsp_done) begin
        build_ack();
      end
      rsp_ready <= slow ? ~rsp_ready : 1'b1;
    end
  end
endmodule

// [tb/tb_registration_response_ack_codec.sv]
// self-checking testbench of the registration response codec
`timescale 1ns/1ps
module tb_registration_response_ack_codec;
  typedef logic [7:0] rrc_bq_t[$];
  logic clk;
  logic rst;
  logic req_valid;
  logic req_ready;
  rrc_pkg::rrc_byte_s req_byte;
  logic [31:0] cap_known;
  logic [31:0] cap_grant;
  logic auth_fail;
  logic [7:0] flow_code;
  logic [15:0] svc_base;
  logic rsp_valid;
  logic rsp_ready;
  rrc_pkg::rrc_byte_s rsp_byte;
  logic [7:0] rsp_code;
  logic rsp_done;
  logic busy;
  logic slow;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  rrc_codec dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_byte(req_byte), .cap_known(cap_known), .cap_grant(cap_grant), .auth_fail(auth_fail),
    .flow_code(flow_code), .svc_base(svc_base), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_byte(rsp_byte), .rsp_code(rsp_code), .rsp_done(rsp_done), .busy(busy));

  rrc_modem_model modem_u (.clk(clk), .rst(rst), .slow(slow), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_byte(rsp_byte), .rsp_code(rsp_code), .rsp_done(rsp_done));

  // ********************************
  // clock and hang guard
  // ********************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("mismatch t=%0t run too long", $time);
      test_done();
    end
  end

  // ********************************
  // compare and report
  // ********************************
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e, input string m);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t %s got %b exp %b", $time, m, g, e);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ********************************
  // one message through and back
  // ********************************
  task automatic run(input rrc_bq_t req, input rrc_bq_t exp, input logic [7:0] code);
    int n;
    int acks;
    modem_u.got.delete();
    acks = modem_u.ack_n;
    foreach (req[i]) begin
      @(negedge clk);
      chk_bit(req_ready, 1'b1, "request ready");
      req_valid = 1'b1;
      req_byte = '{data: req[i], last: (i == req.size() - 1)};
      @(posedge clk);
    end
    @(negedge clk);
    req_valid = 1'b0;
    req_byte = '0;
    if (exp.size() > 0) begin
      chk_bit(busy, 1'b1, "busy after last");
      chk_bit(req_ready, 1'b0, "refuse while busy");
    end
    n = 0;
    while (rsp_done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk_bit(rsp_done, 1'b1, "done pulse");
    chk_byte(rsp_code, code, "response code");
    chk_byte(8'(modem_u.got.size()), 8'(exp.size()), "byte count");
    foreach (modem_u.got[i]) begin
      if (i < exp.size()) begin
        chk_byte(modem_u.got[i].data, exp[i], "response byte");
        chk_bit(modem_u.got[i].last, (i == exp.size() - 1), "last flag");
      end
    end
    @(negedge clk);
    chk_bit(rsp_done, 1'b0, "done one cycle");
    chk_byte(8'(modem_u.ack_n - acks), 8'h01, "one ack per response");
    chk_byte(modem_u.ack_code, code, "ack code");
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic t_caps();
    slow = 1'b1;
    cap_known = 32'h0000_1488;
    cap_grant = 32'h0000_0488;
    run('{8'h2a, 8'h02, 8'hff, 8'hff, 8'h05, 8'h10, 8'h07, 8'h01, 8'h01, 8'h09, 8'h01, 8'h01,
      8'h0a, 8'h01, 8'h00, 8'h0c, 8'h01, 8'h01, 8'h03, 8'h02, 8'hab, 8'hcd},
      '{8'h05, 8'h10, 8'h07, 8'h01, 8'h01, 8'h09, 8'h01, 8'h00, 8'h0a, 8'h01, 8'h00,
      8'h0c, 8'h01, 8'h00, 8'h03, 8'h02, 8'hab, 8'hcd}, flow_code);
    $display("test caps done");
  endtask

  task automatic t_legacy();
    slow = 1'b0;
    run('{8'h04, 8'h03, 8'h01, 8'h01, 8'h03, 8'h04, 8'h06, 8'h03, 8'h01, 8'h44, 8'h01,
      8'h01, 8'h10},
      '{8'h01, 8'h07, 8'h01, 8'h01, 8'h03, 8'h02, 8'h02, 8'h12, 8'h33,
      8'h01, 8'h07, 8'h01, 8'h01, 8'h10, 8'h02, 8'h02, 8'h12, 8'h40},
      rrc_pkg::CODE_OK);
    chk_byte(modem_u.ack_svc[15:8], 8'h12, "ack id high");
    chk_byte(modem_u.ack_svc[7:0], 8'h33, "ack id low");
    $display("test legacy done");
  endtask

  task automatic t_mixed();
    slow = 1'b1;
    run('{8'h04, 8'h03, 8'h01, 8'h01, 8'h01, 8'h05, 8'h03, 8'h07, 8'h01, 8'h01},
      '{8'h05, 8'h03, 8'h07, 8'h01, 8'h01, 8'h01, 8'h07, 8'h01, 8'h01, 8'h01, 8'h02,
      8'h02, 8'h12, 8'h31}, rrc_pkg::CODE_OK);
    $display("test mixed done");
  endtask

  task automatic t_badid();
    slow = 1'b0;
    run('{8'h04, 8'h03, 8'h01, 8'h01, 8'h05, 8'h04, 8'h03, 8'h01, 8'h01, 8'h05},
      '{}, rrc_pkg::CODE_COS);
    run('{8'h04, 8'h03, 8'h01, 8'h01, 8'h11}, '{}, rrc_pkg::CODE_COS);
    run('{8'h04, 8'h03, 8'h01, 8'h01, 8'h00}, '{}, rrc_pkg::CODE_COS);
    $display("test bad id done");
  endtask

  task automatic t_noid();
    run('{8'h04, 8'h03, 8'h01, 8'h01, 8'h02, 8'h04, 8'h03, 8'h07, 8'h01, 8'h02},
      '{}, rrc_pkg::CODE_COS);
    $display("test missing id done");
  endtask

  task automatic t_auth();
    auth_fail = 1'b1;
    run('{8'h04, 8'h03, 8'h01, 8'h01, 8'h02}, '{}, rrc_pkg::CODE_AUTH);
    auth_fail = 1'b0;
    $display("test auth done");
  endtask

  task automatic t_chg();
    int acks;
    acks = modem_u.ack_n;
    modem_u.chg_req();
    repeat (4) @(negedge clk);
    chk_byte(8'(modem_u.ack_n - acks), 8'h00, "change request answered");
    chk_byte(modem_u.ack_code, rrc_pkg::CODE_AUTH, "change request acted on");
    $display("test change request done");
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_byte = '0;
    cap_known = 32'h0;
    cap_grant = 32'h0;
    auth_fail = 1'b0;
    flow_code = 8'h05;
    svc_base = 16'h1230;
    slow = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk_bit(req_ready, 1'b1, "reset ready");
    chk_bit(rsp_valid, 1'b0, "reset valid");
    chk_bit(busy, 1'b0, "reset busy");
    chk_byte(rsp_code, 8'h00, "reset code");
    rst = 1'b0;
    t_caps();
    t_legacy();
    t_mixed();
    t_badid();
    t_noid();
    t_auth();
    t_chg();
    test_done();
  end
endmodule
